// file: rtl/flash_status_pkg.sv
package flash_status_pkg;

    localparam int CLK_MHZ = 20;

    // Least time in ns to whole clock cycles, rounded up, never below one
    function automatic int ns_to_cyc(input int ns);
        int c;
        c = (ns * CLK_MHZ + 999) / 1000;
        return (c < 1) ? 1 : c;
    endfunction : ns_to_cyc

    localparam int T_PRECHARGE_NS = 10;
    localparam int T_ROW_TO_COL_NS = 15;
    localparam int T_READ_ACCESS_NS = 95;
    localparam int T_WRITE_PULSE_NS = 95;
    localparam int T_RESET_LOW_NS = 100;
    localparam int T_RESET_RECOVERY_NS = 300;

    localparam int PRECHARGE_CYC = ns_to_cyc(T_PRECHARGE_NS);
    localparam int ROW_TO_COL_CYC = ns_to_cyc(T_ROW_TO_COL_NS);
    localparam int READ_ACCESS_CYC = ns_to_cyc(T_READ_ACCESS_NS);
    localparam int WRITE_PULSE_CYC = ns_to_cyc(T_WRITE_PULSE_NS);
    localparam int RESET_LOW_CYC = ns_to_cyc(T_RESET_LOW_NS);
    localparam int RESET_RECOVERY_CYC = ns_to_cyc(T_RESET_RECOVERY_NS);

    localparam int CNT_W = 8;
    localparam int ADDR_W = 10;
    localparam int DATA_W = 16;

    localparam logic [7:0] CMD_READ_COMPAT = 8'h70;
    localparam logic [7:0] CMD_READ_EXT = 8'h71;
    localparam logic [7:0] CMD_CLEAR = 8'h50;

    localparam int READY_BIT = 7;
    localparam int SUSPEND_BIT = 6;
    localparam int OP_ERROR_BIT = 5;
    localparam int WRITE_ERROR_BIT = 4;
    localparam int COMPAT_SUPPLY_BIT = 3;
    localparam int BLOCK_SUPPLY_BIT = 2;
    localparam int BLOCK_LEVEL_BIT = 1;

    localparam logic [7:0] COMPAT_MASK = 8'hF8;
    localparam logic [7:0] GLOBAL_MASK = 8'hE0;
    localparam logic [7:0] BLOCK_MASK = 8'hE6;

    typedef enum logic [1:0] {
        OP_READ_COMPAT = 2'h0,
        OP_READ_EXT = 2'h1,
        OP_CLEAR = 2'h2,
        OP_RESET = 2'h3
    } host_op_t;

    typedef struct packed {
        host_op_t op;
        logic ext_block;
        logic [2*ADDR_W-1:0] addr;
    } host_req_t;

    typedef struct packed {
        logic ras_n;
        logic cas_n;
        logic oe_n;
        logic we_n;
    } flash_strobe_t;

    localparam flash_strobe_t STROBE_IDLE = 4'hF;

endpackage : flash_status_pkg

// file: rtl/flash_bus_cycle.sv
`timescale 1ns/10ps
module flash_bus_cycle
    import flash_status_pkg::*;
(
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic start_in,
    input wire logic write_in,
    input wire logic [ADDR_W-1:0] row_in,
    input wire logic [ADDR_W-1:0] col_in,
    input wire logic [DATA_W-1:0] wdata_in,
    input wire logic [DATA_W-1:0] dq_in,
    output flash_strobe_t strobe_out,
    output logic [ADDR_W-1:0] addr_out,
    output logic [DATA_W-1:0] dq_out,
    output logic dq_oe_out,
    output logic [DATA_W-1:0] rdata_out,
    output logic done_out
);

    typedef enum logic [3:0] {
        CY_IDLE = 4'b0001,
        CY_ROW = 4'b0010,
        CY_COL = 4'b0100,
        CY_PRE = 4'b1000
    } cycle_state_t;

    cycle_state_t state_q;
    logic [CNT_W-1:0] cnt_q;
    logic write_q;
    logic [ADDR_W-1:0] col_q;

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_q <= CY_IDLE;
            cnt_q <= '0;
            write_q <= 1'b0;
            col_q <= '0;
            strobe_out <= STROBE_IDLE;
            addr_out <= '0;
            dq_out <= '0;
            dq_oe_out <= 1'b0;
            rdata_out <= '0;
            done_out <= 1'b0;
        end else begin
            done_out <= 1'b0;
            case (state_q)
                CY_IDLE: begin
                    if (start_in) begin
                        // Row address latched on the RAS falling edge
                        write_q <= write_in;
                        col_q <= col_in;
                        addr_out <= row_in;
                        dq_out <= wdata_in;
                        dq_oe_out <= write_in;
                        strobe_out.ras_n <= 1'b0;
                        cnt_q <= CNT_W'(ROW_TO_COL_CYC);
                        state_q <= CY_ROW;
                    end
                end
                CY_ROW: begin
                    if (cnt_q == CNT_W'(1)) begin
                        addr_out <= col_q;
                        strobe_out.cas_n <= 1'b0;
                        strobe_out.oe_n <= write_q;
                        strobe_out.we_n <= !write_q;
                        cnt_q <= write_q ? CNT_W'(WRITE_PULSE_CYC)
                                         : CNT_W'(READ_ACCESS_CYC);
                        state_q <= CY_COL;
                    end else begin
                        cnt_q <= cnt_q - CNT_W'(1);
                    end
                end
                CY_COL: begin
                    if (cnt_q == CNT_W'(1)) begin
                        // Sample before strobes rise; data is not held past them
                        if (!write_q) begin
                            rdata_out <= dq_in;
                        end
                        strobe_out <= STROBE_IDLE;
                        cnt_q <= CNT_W'(PRECHARGE_CYC);
                        state_q <= CY_PRE;
                    end else begin
                        cnt_q <= cnt_q - CNT_W'(1);
                    end
                end
                CY_PRE: begin
                    dq_oe_out <= 1'b0;
                    if (cnt_q == CNT_W'(1)) begin
                        done_out <= 1'b1;
                        state_q <= CY_IDLE;
                    end else begin
                        cnt_q <= cnt_q - CNT_W'(1);
                    end
                end
                default: begin
                    state_q <= CY_IDLE;
                    strobe_out <= STROBE_IDLE;
                end
            endcase
        end
    end

endmodule : flash_bus_cycle

// file: rtl/flash_status_host.sv
// How it works
// (R1) Device reports engine ready in compatible status bit 7.
// (R2) Host waits for ready before judging suspend and error bits.
// (R3) Device shows erase suspended in compatible status bit 6.
// (R4) Device sets erase error bit 5 on failed block erase.
// (R5) Both write and erase errors: bad sequence; host clears status.
// (R6) Device sets write error bit 4 on failed data write.
// (R7) Device sets supply error bit 3 and aborts on supply fault.
// (R8) Engine samples supply only after write or erase is accepted.
// (R9) Host masks the three reserved low compatible status bits.
// (R10) Global status bit 7 reports engine ready.
// (R11) Global status bit 6 shows an operation suspended.
// (R12) Global status bit 5 flags an unsuccessful operation.
// (R13) Host masks the five reserved low global status bits.
// (R14) Host waits for completion before checking suspend or error.
// (R15) Block status bit 7 shows that block ready.
// (R16) Block status bit 6 is one when the block is unlocked.
// (R17) Block status bit 5 flags a failed operation on the block.
// (R18) Block status bit 2 flags a supply fault abort.
// (R19) Block status bit 1 is one at 5 V supply, zero at 12 V.
// (R20) Host masks reserved block status bits 4, 3 and 0.
// (R21) Host confirms block completion before judging its status.
// (R22) Command 70H then a read returns compatible status.
// (R23) Command 71H then a read at an address returns extended status.
// (R24) Command 50H clears error and supply status bits.
// (R25) Reset pin low ends engine work and clears all status.
// (R26) Error flags stay set until a clear command or reset.
`timescale 1ns/10ps
module flash_status_host
    import flash_status_pkg::*;
#(
    parameter int MAX_POLL = 1000
) (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic start_in,
    input host_req_t req_in,
    input wire logic ready_busy_in,
    input wire logic [DATA_W-1:0] dq_in,
    output flash_strobe_t strobe_out,
    output logic powerdown_reset_n_out,
    output logic [ADDR_W-1:0] addr_out,
    output logic [DATA_W-1:0] dq_out,
    output logic dq_oe_out,
    output logic busy_out,
    output logic done_out,
    output logic [7:0] status_out,
    output logic op_error_out,
    output logic supply_error_out,
    output logic suspended_out,
    output logic retry_out,
    output logic timeout_out
);

    typedef enum logic [8:0] {
        M_IDLE = 9'b000000001,
        M_CMD = 9'b000000010,
        M_WAIT = 9'b000000100,
        M_READ = 9'b000001000,
        M_CHECK = 9'b000010000,
        M_CLEAR = 9'b000100000,
        M_RESET = 9'b001000000,
        M_RECOVER = 9'b010000000,
        M_DONE = 9'b100000000
    } host_state_t;

    localparam int POLL_W = $clog2(MAX_POLL + 1);

    host_state_t state_q;
    host_req_t req_q;
    logic cy_start_q;
    logic cy_write_q;
    logic [7:0] cmd_q;
    logic [POLL_W-1:0] poll_q;
    logic [CNT_W-1:0] cnt_q;
    logic [ADDR_W-1:0] row_q;
    logic [ADDR_W-1:0] col_q;
    logic cy_done;
    logic [DATA_W-1:0] cy_rdata;
    logic [7:0] raw;
    logic [7:0] mask;
    logic poll_limit;

    assign raw = cy_rdata[7:0];
    assign poll_limit = (poll_q == POLL_W'(MAX_POLL));

    // Reserved bits are never passed on or judged
    always_comb begin
        if (req_q.op == OP_READ_COMPAT) begin
            mask = COMPAT_MASK; // [R9]
        end else if (req_q.ext_block) begin
            mask = BLOCK_MASK; // [R20]
        end else begin
            mask = GLOBAL_MASK; // [R13]
        end
    end

    flash_bus_cycle u_cycle (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .start_in(cy_start_q),
        .write_in(cy_write_q),
        .row_in(row_q),
        .col_in(col_q),
        .wdata_in({8'h00, cmd_q}),
        .dq_in(dq_in),
        .strobe_out(strobe_out),
        .addr_out(addr_out),
        .dq_out(dq_out),
        .dq_oe_out(dq_oe_out),
        .rdata_out(cy_rdata),
        .done_out(cy_done)
    );

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_q <= M_IDLE;
            req_q <= '0;
            cy_start_q <= 1'b0;
            cy_write_q <= 1'b0;
            cmd_q <= '0;
            poll_q <= '0;
            cnt_q <= '0;
            row_q <= '0;
            col_q <= '0;
            powerdown_reset_n_out <= 1'b1;
            busy_out <= 1'b0;
            done_out <= 1'b0;
            status_out <= '0;
            op_error_out <= 1'b0;
            supply_error_out <= 1'b0;
            suspended_out <= 1'b0;
            retry_out <= 1'b0;
            timeout_out <= 1'b0;
        end else begin
            cy_start_q <= 1'b0;
            done_out <= 1'b0;
            case (state_q)
                M_IDLE: begin
                    if (start_in) begin
                        req_q <= req_in;
                        busy_out <= 1'b1;
                        poll_q <= '0;
                        retry_out <= 1'b0;
                        timeout_out <= 1'b0;
                        row_q <= '0;
                        col_q <= '0;
                        cy_write_q <= 1'b1;
                        case (req_in.op)
                            OP_READ_COMPAT: cmd_q <= CMD_READ_COMPAT; // [R22]
                            OP_READ_EXT: cmd_q <= CMD_READ_EXT; // [R23]
                            default: cmd_q <= CMD_CLEAR; // [R24]
                        endcase
                        if (req_in.op == OP_RESET) begin
                            powerdown_reset_n_out <= 1'b0; // [R25]
                            cnt_q <= CNT_W'(RESET_LOW_CYC);
                            state_q <= M_RESET;
                        end else begin
                            cy_start_q <= 1'b1;
                            state_q <= M_CMD;
                        end
                    end
                end
                M_CMD: begin
                    if (cy_done) begin
                        state_q <= (req_q.op == OP_CLEAR) ? M_DONE : M_WAIT;
                    end
                end
                M_WAIT: begin
                    // Pin released means ready or suspended; bit 7 decides
                    if (ready_busy_in) begin
                        cy_write_q <= 1'b0;
                        if (req_q.op == OP_READ_EXT) begin
                            row_q <= req_q.addr[2*ADDR_W-1:ADDR_W]; // [R23]
                            col_q <= req_q.addr[ADDR_W-1:0];
                        end
                        cy_start_q <= 1'b1;
                        state_q <= M_READ;
                    end else if (poll_limit) begin
                        timeout_out <= 1'b1;
                        state_q <= M_DONE;
                    end else begin
                        poll_q <= poll_q + POLL_W'(1);
                    end
                end
                M_READ: begin
                    if (cy_done) begin
                        state_q <= M_CHECK;
                    end
                end
                M_CHECK: begin
                    if (!raw[READY_BIT]) begin // [R2] [R14] [R21] [R1]
                        // Status stays selected, so only the read repeats
                        if (poll_limit) begin
                            timeout_out <= 1'b1;
                            state_q <= M_DONE;
                        end else begin
                            poll_q <= poll_q + POLL_W'(1);
                            cy_start_q <= 1'b1;
                            state_q <= M_READ;
                        end
                    end else begin
                        status_out <= raw & mask;
                        suspended_out <= !req_q.ext_block
                            && raw[SUSPEND_BIT];
                        if (req_q.op == OP_READ_COMPAT) begin
                            op_error_out <= raw[OP_ERROR_BIT]
                                || raw[WRITE_ERROR_BIT]; // [R4] [R6]
                            supply_error_out <= raw[COMPAT_SUPPLY_BIT];
                        end else begin
                            op_error_out <= raw[OP_ERROR_BIT];
                            supply_error_out <= req_q.ext_block
                                && raw[BLOCK_SUPPLY_BIT];
                        end
                        if (req_q.op == OP_READ_COMPAT && raw[OP_ERROR_BIT]
                            && raw[WRITE_ERROR_BIT]) begin
                            // Sequence error: clear so the caller can retry
                            retry_out <= 1'b1; // [R5]
                            cmd_q <= CMD_CLEAR; // [R5]
                            cy_write_q <= 1'b1;
                            row_q <= '0;
                            col_q <= '0;
                            cy_start_q <= 1'b1;
                            state_q <= M_CLEAR;
                        end else begin
                            state_q <= M_DONE;
                        end
                    end
                end
                M_CLEAR: begin
                    if (cy_done) begin
                        state_q <= M_DONE;
                    end
                end
                M_RESET: begin
                    if (cnt_q == CNT_W'(1)) begin
                        powerdown_reset_n_out <= 1'b1;
                        cnt_q <= CNT_W'(RESET_RECOVERY_CYC);
                        state_q <= M_RECOVER;
                    end else begin
                        cnt_q <= cnt_q - CNT_W'(1);
                    end
                end
                M_RECOVER: begin
                    if (cnt_q == CNT_W'(1)) begin
                        // Device status is all clear after the pulse
                        status_out <= '0; // [R25]
                        op_error_out <= 1'b0;
                        supply_error_out <= 1'b0;
                        suspended_out <= 1'b0;
                        state_q <= M_DONE;
                    end else begin
                        cnt_q <= cnt_q - CNT_W'(1);
                    end
                end
                M_DONE: begin
                    done_out <= 1'b1;
                    busy_out <= 1'b0;
                    state_q <= M_IDLE;
                end
                default: begin
                    state_q <= M_IDLE;
                    powerdown_reset_n_out <= 1'b1;
                    busy_out <= 1'b0;
                end
            endcase
        end
    end

endmodule : flash_status_host

// file: verif/flash_status_host_checker.sv
`timescale 1ns/10ps
module flash_status_host_checker
    import flash_status_pkg::*;
(
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic start_in,
    input host_req_t req_in,
    input flash_strobe_t strobe_out,
    input wire logic powerdown_reset_n_out,
    input wire logic [DATA_W-1:0] dq_out,
    input wire logic dq_oe_out,
    input wire logic busy_out,
    input wire logic done_out,
    input wire logic [7:0] status_out,
    input wire logic retry_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!reset_n_in);

    sequence s_take(host_op_t op);
        start_in && !busy_out && req_in.op == op;
    endsequence
    sequence s_reset_pulse;
        !powerdown_reset_n_out [*2] ##1 powerdown_reset_n_out;
    endsequence

    chk_clear_done: assert property (
        s_take(OP_CLEAR) |-> ##[8:10] done_out)
        else $error("clear did not complete in time");
    chk_reset_pin: assert property (
        s_take(OP_RESET) |-> ##[1:2] !powerdown_reset_n_out)
        else $error("reset request did not pull the reset pin");
    chk_reset_width: assert property (
        $fell(powerdown_reset_n_out) |-> s_reset_pulse)
        else $error("reset pin pulse width wrong");
    chk_busy_take: assert property (
        start_in && !busy_out |=> busy_out)
        else $error("busy not raised after request");
    chk_done_pulse: assert property (done_out |=> !done_out)
        else $error("done longer than one cycle");
    chk_done_idle: assert property (done_out |-> !busy_out)
        else $error("busy still high at done");
    chk_bus_turn: assert property (!strobe_out.oe_n |-> !dq_oe_out)
        else $error("host drives data during a read");
    chk_cmd_byte: assert property (
        !strobe_out.we_n && !strobe_out.cas_n
        |-> dq_oe_out && dq_out[15:8] == 8'h00)
        else $error("command write without data drive");
    chk_status_hold: assert property (
        !busy_out && !start_in |=> $stable(status_out))
        else $error("status changed while idle");
    chk_retry_flags: assert property (
        done_out && retry_out |-> status_out[5:4] == 2'b11)
        else $error("retry without both error bits");
    chk_mask_low: assert property (
        done_out |-> status_out[0] == 1'b0)
        else $error("reserved status bit not masked");
endmodule : flash_status_host_checker

// file: verif/flash_device_model.sv
`timescale 1ns/10ps
module flash_device_model
    import flash_status_pkg::*;
(
    input flash_strobe_t strobe_in,
    input wire logic powerdown_reset_n_in,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic [DATA_W-1:0] dq_in,
    input wire logic busy_in,
    input wire logic susp_in,
    input wire logic post_in,
    input wire logic [2:0] result_in,
    input wire logic level5_in,
    input wire logic unlocked_in,
    output logic ready_busy_out,
    output logic [DATA_W-1:0] dq_out
);
    logic erase_err_q = 1'b0, write_err_q = 1'b0, supply_err_q = 1'b0;
    logic op_err_q = 1'b0, level5_q = 1'b0, ext_q = 1'b0;
    logic [ADDR_W-1:0] row_q = '0;
    logic [DATA_W-1:0] last_q = '0;
    logic [7:0] compat, glob, blk, sel;
    logic rd;

    // Pulled up pin: released unless the engine is busy
    assign ready_busy_out = ~busy_in;
    // Reserved bits read as ones so a host that forgets to mask is caught
    assign compat = {~busy_in, susp_in, erase_err_q, write_err_q,
        supply_err_q, 3'b111};
    assign glob = {~busy_in, susp_in, op_err_q, 5'h1F};
    assign blk = {~busy_in, unlocked_in, op_err_q, 2'b11, supply_err_q,
        level5_q, 1'b1};
    assign sel = !ext_q ? compat : (row_q != '0 ? blk : glob);
    assign rd = !strobe_in.ras_n && !strobe_in.cas_n && !strobe_in.oe_n
        && strobe_in.we_n;
    // Released bus shows the inverse of the last word, never stale data
    assign dq_out = rd ? {8'h00, sel} : ~last_q;

    always @(negedge rd) last_q = {8'h00, sel};
    // Latch a moment after the fall: address and strobe share one edge
    always @(negedge strobe_in.ras_n) begin
        #1 row_q = addr_in;
    end

    // Commands latch as the write strobe rises; the data word still stands
    always @(posedge strobe_in.we_n or posedge post_in
        or negedge powerdown_reset_n_in) begin
        if (!powerdown_reset_n_in) begin
            {erase_err_q, write_err_q, supply_err_q, op_err_q} = '0;
            {level5_q, ext_q} = '0;
        end else if (post_in) begin
            // Supply level is only sampled when an operation ends
            level5_q = level5_in;
            erase_err_q |= result_in == 3'h1
                || result_in == 3'h4;
            write_err_q |= result_in == 3'h2
                || result_in == 3'h4;
            supply_err_q |= result_in == 3'h3;
            op_err_q |= result_in != 3'h0;
        end else begin
            case (dq_in[7:0])
                CMD_READ_COMPAT: ext_q = 1'b0;
                CMD_READ_EXT: ext_q = 1'b1;
                CMD_CLEAR: {erase_err_q, write_err_q, supply_err_q,
                    op_err_q} = '0;
                default: ;
            endcase
        end
    end
endmodule : flash_device_model

// file: verif/testbench.sv
`timescale 1ns/10ps
module testbench;
    import flash_status_pkg::*;
    logic clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic start_in = 1'b0;
    host_req_t req_in = '0;
    logic busy_in = 1'b0, susp_in = 1'b0, post_in = 1'b0;
    logic level5_in = 1'b0, unlocked_in = 1'b0;
    logic [2:0] result_in = 3'h0;
    logic ready_busy, pdr_n, dq_oe, busy_out, done_out, op_err, sup_err;
    logic susp_out, retry_out, timeout_out;
    flash_strobe_t strobe;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq_to_dev, dq_to_host;
    logic [7:0] status_out;
    int err_count = 0;
    int check_count = 0;
    int cycles = 0;

    always #25 clk_in = ~clk_in;

    flash_status_host #(.MAX_POLL(4)) dut (.clk_in(clk_in),
        .reset_n_in(reset_n_in), .start_in(start_in), .req_in(req_in),
        .ready_busy_in(ready_busy), .dq_in(dq_to_host), .strobe_out(strobe),
        .powerdown_reset_n_out(pdr_n), .addr_out(addr), .dq_out(dq_to_dev),
        .dq_oe_out(dq_oe), .busy_out(busy_out), .done_out(done_out),
        .status_out(status_out), .op_error_out(op_err),
        .supply_error_out(sup_err), .suspended_out(susp_out),
        .retry_out(retry_out), .timeout_out(timeout_out));

    flash_device_model model (.strobe_in(strobe), .powerdown_reset_n_in(pdr_n),
        .addr_in(addr), .dq_in(dq_to_dev), .busy_in(busy_in),
        .susp_in(susp_in), .post_in(post_in), .result_in(result_in),
        .level5_in(level5_in), .unlocked_in(unlocked_in),
        .ready_busy_out(ready_busy), .dq_out(dq_to_host));

    task automatic check(input string name, input logic [7:0] got,
        input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic run(input host_op_t op, input logic ext,
        input logic [19:0] a);
        int n;
        @(posedge clk_in);
        #1;
        req_in = '{op: op, ext_block: ext, addr: a};
        start_in = 1'b1;
        @(posedge clk_in);
        #1;
        start_in = 1'b0;
        for (n = 0; n < 400 && done_out !== 1'b1; n++) begin
            @(posedge clk_in);
            #1;
        end
        check("done", done_out, 8'h01);
    endtask : run

    task automatic post(input logic [2:0] res);
        result_in = res;
        #1 post_in = 1'b1;
        #1 post_in = 1'b0;
    endtask : post

    task automatic t_results;
        logic [7:0] exp [4] = '{8'hA0, 8'h90, 8'h88, 8'hB0};
        for (int i = 0; i < 4; i++) begin
            post(3'(i + 1));
            run(OP_READ_COMPAT, 1'b0, '0);
            check("compat", status_out, exp[i]);
            check("op_err", op_err, i != 2);
            check("supply", sup_err, i == 2);
            check("retry", retry_out, i == 3);
            if (i == 3) begin
                run(OP_READ_COMPAT, 1'b0, '0);
                check("auto_clear", status_out, 8'h80);
            end
            run(OP_CLEAR, 1'b0, '0);
            run(OP_READ_COMPAT, 1'b0, '0);
            check("cleared", status_out, 8'h80);
        end
    endtask : t_results

    task automatic t_ext;
        level5_in = 1'b1;
        unlocked_in = 1'b1;
        post(3'h2);
        run(OP_READ_EXT, 1'b0, '0);
        check("global", status_out, 8'hA0);
        check("g_err", op_err, 8'h01);
        run(OP_READ_EXT, 1'b1, 20'h00400);
        check("block", status_out, 8'hE2);
        level5_in = 1'b0;
        unlocked_in = 1'b0;
        post(3'h3);
        run(OP_READ_EXT, 1'b1, 20'h00400);
        check("blk_sup", status_out, 8'hA4);
        check("sup_out", sup_err, 8'h01);
        run(OP_CLEAR, 1'b0, '0);
        run(OP_READ_EXT, 1'b1, 20'h00400);
        check("blk_clr", status_out, 8'h80);
        run(OP_READ_EXT, 1'b0, '0);
        check("glb_clr", status_out, 8'h80);
    endtask : t_ext

    task automatic t_sticky;
        post(3'h1);
        post(3'h0);
        run(OP_READ_COMPAT, 1'b0, '0);
        check("sticky", status_out, 8'hA0);
        run(OP_CLEAR, 1'b0, '0);
    endtask : t_sticky

    task automatic t_suspend;
        susp_in = 1'b1;
        run(OP_READ_COMPAT, 1'b0, '0);
        check("c_susp", status_out, 8'hC0);
        check("susp_out", susp_out, 8'h01);
        run(OP_READ_EXT, 1'b0, '0);
        check("g_susp", status_out, 8'hC0);
        susp_in = 1'b0;
    endtask : t_suspend

    task automatic t_busy;
        busy_in = 1'b1;
        run(OP_READ_COMPAT, 1'b0, '0);
        check("timeout", timeout_out, 8'h01);
        busy_in = 1'b0;
        run(OP_READ_COMPAT, 1'b0, '0);
        check("ready", status_out, 8'h80);
        check("no_tmo", timeout_out, 8'h00);
    endtask : t_busy

    task automatic t_reset;
        post(3'h2);
        run(OP_RESET, 1'b0, '0);
        check("rst_out", status_out, 8'h00);
        run(OP_READ_COMPAT, 1'b0, '0);
        check("rst_dev", status_out, 8'h80);
    endtask : t_reset

    task automatic final_report;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : final_report

    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            final_report;
        end
    end

    initial begin
        repeat (6) @(posedge clk_in);
        #1 reset_n_in = 1'b1;
        t_results;
        t_ext;
        t_sticky;
        t_suspend;
        t_busy;
        t_reset;
        final_report;
    end
endmodule : testbench

bind flash_status_host flash_status_host_checker u_chk (.clk_in(clk_in),
    .reset_n_in(reset_n_in), .start_in(start_in), .req_in(req_in),
    .strobe_out(strobe_out), .powerdown_reset_n_out(powerdown_reset_n_out),
    .dq_out(dq_out), .dq_oe_out(dq_oe_out), .busy_out(busy_out),
    .done_out(done_out), .status_out(status_out), .retry_out(retry_out));
